// ===== ogt_map.vh
`ifndef OGT_MAP_VH
`define OGT_MAP_VH
// ----------------------------------------------------------------
// Register indices (printed offsets, not all multiples of four)
// ----------------------------------------------------------------
`define OGT_IDX_A_PH0_IN2    12'h346
`define OGT_IDX_A_PH90_IN1   12'h348
`define OGT_IDX_A_PH90_IN2   12'h34a
`define OGT_IDX_B_PH0_IN1    12'h34c
`define OGT_IDX_B_PH0_IN2    12'h34e
`define OGT_IDX_BANK0_FINE_GAIN      12'h360
`define OGT_IDX_STATUS       12'h370
// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define OGT_OFS_TRIM_MSB     11
`define OGT_OFS_REG_W        16
`define OGT_GAIN_TRIM_MSB    4
`define OGT_GAIN_REG_W       8
`define OGT_NUM_OFS          5
// Status register bits
`define OGT_ST_LOADED        0
`define OGT_ST_BUSY          1
// ----------------------------------------------------------------
// Fuse load timing
// ----------------------------------------------------------------
`define OGT_FUSE_WORDS       6
`endif

// ===== ogt_fuse_loader.v
`default_nettype none
`include "ogt_map.vh"
// Walks fuse storage once after reset, issuing one load strobe per word
module ogt_fuse_loader (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        clk_en,
   input  wire [15:0] fuse_rdata,
   output reg  [2:0]  fuse_addr,
   output reg         load_stb,
   output reg  [15:0] load_data,
   output reg  [2:0]  load_sel,
   output reg         done
);
   // Last fuse word index, cut to the address width on purpose
   localparam integer LAST_I = `OGT_FUSE_WORDS - 1;
   localparam [2:0]   LAST   = LAST_I[2:0];

   // ----------------------------------------------------------------
   // Sequencer: address then capture, one word per cycle
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fuse_addr <= 3'h0;
         load_stb  <= 1'b0;
         load_data <= 16'h0000;
         load_sel  <= 3'h0;
         done      <= 1'b0;
      end else if (clk_en) begin
         load_stb <= 1'b0;
         if (!done) begin
            load_stb  <= 1'b1;
            load_data <= fuse_rdata;
            load_sel  <= fuse_addr;
            if (fuse_addr == LAST) begin
               done <= 1'b1;
            end else begin
               fuse_addr <= fuse_addr + 3'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== ogt_addr_dec.v
`default_nettype none
`include "ogt_map.vh"
// Maps a byte address to a register slot; slot 7 means unmapped
module ogt_addr_dec (
   input  wire [13:0] byte_addr,
   output reg  [2:0]  slot
);
   // Word index is byte address over four
   wire [11:0] idx = byte_addr[13:2];

   always @* begin
      if (byte_addr[1:0] != 2'b00) begin
         slot = 3'h7;
      end else if (idx == `OGT_IDX_A_PH0_IN2) begin
         slot = 3'h0;
      end else if (idx == `OGT_IDX_A_PH90_IN1) begin
         slot = 3'h1;
      end else if (idx == `OGT_IDX_A_PH90_IN2) begin
         slot = 3'h2;
      end else if (idx == `OGT_IDX_B_PH0_IN1) begin
         slot = 3'h3;
      end else if (idx == `OGT_IDX_B_PH0_IN2) begin
         slot = 3'h4;
      end else if (idx == `OGT_IDX_BANK0_FINE_GAIN) begin
         slot = 3'h5;
      end else if (idx == `OGT_IDX_STATUS) begin
         slot = 3'h6;
      end else begin
         slot = 3'h7;
      end
   end
endmodule
`default_nettype wire

// ===== ogt_trim_regs.v
`default_nettype none
`include "ogt_map.vh"
module ogt_trim_regs (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        clk_en,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Fuse storage port
   input  wire [15:0] fuse_rdata,
   output reg  [2:0]  fuse_addr_o,
   // Calibration path
   input  wire        fg_cal_en,
   input  wire        core_b_sel,
   input  wire        input2_sel,
   input  wire        phase90_sel,
   output reg  [11:0] offset_corr,
   output reg         offset_valid,
   output reg  [4:0]  gain_trim_b0,
   output reg  [63:0] trim_reserved
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg  [15:0] ofs_r [0:`OGT_NUM_OFS-1];
   reg  [7:0]  gain_r;
   reg         wr_pend_r;
   reg  [2:0]  wr_slot_r;
   wire [2:0]  slot;
   wire [2:0]  fuse_addr;
   wire        load_stb;
   wire [15:0] load_data;
   wire [2:0]  load_sel;
   wire        loaded;
   wire        take = hsel & hready & htrans[1];

   ogt_addr_dec u_dec (
      .byte_addr (haddr[13:0]),
      .slot      (slot)
   );

   ogt_fuse_loader u_fuse (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .clk_en     (clk_en),
      .fuse_rdata (fuse_rdata),
      .fuse_addr  (fuse_addr),
      .load_stb   (load_stb),
      .load_data  (load_data),
      .load_sel   (load_sel),
      .done       (loaded)
   );

   // Pick one offset slot from sampling state; 7 means none applies
   function [2:0] ofs_pick;
      input b;
      input in2;
      input ph90;
      begin
         case ({b, ph90, in2})
            3'b001: ofs_pick = 3'h0;
            3'b010: ofs_pick = 3'h1;
            3'b011: ofs_pick = 3'h2;
            3'b100: ofs_pick = 3'h3;
            3'b101: ofs_pick = 3'h4;
            default: ofs_pick = 3'h7;
         endcase
      end
   endfunction

   wire [2:0] pick = ofs_pick(core_b_sel, input2_sel, phase90_sel);

   // ----------------------------------------------------------------
   // Bus front end: zero wait, always OKAY
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_slot_r <= 3'h7;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clk_en) begin
         wr_pend_r <= take & hwrite;
         wr_slot_r <= slot;
         if (take & !hwrite) begin
            if (slot < 3'h5) begin
               hrdata <= {16'h0000, ofs_r[slot]};
            end else if (slot == 3'h5) begin
               hrdata <= {24'h000000, gain_r};
            end else if (slot == 3'h6) begin
               hrdata <= {30'h00000000, !loaded, loaded};
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Trim storage: fuse load first, then software writes
   // ----------------------------------------------------------------
   // No reset on the trims: contents come from the fuses instead
   genvar g;
   generate
      for (g = 0; g < `OGT_NUM_OFS; g = g + 1) begin : g_ofs
         always @(posedge hclk) begin
            if (clk_en) begin
               if (load_stb && load_sel == g) begin
                  ofs_r[g] <= load_data;
               end else if (wr_pend_r && wr_slot_r == g) begin
                  ofs_r[g] <= hwdata[15:0];
               end
            end
         end
      end
   endgenerate

   always @(posedge hclk) begin
      if (clk_en) begin
         if (load_stb && load_sel == 3'h5) begin
            gain_r <= load_data[7:0];
         end else if (wr_pend_r && wr_slot_r == 3'h5) begin
            gain_r <= hwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Applied trims, registered; held invalid until fuses are loaded
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         offset_corr   <= 12'h000;
         offset_valid  <= 1'b0;
         gain_trim_b0  <= 5'h00;
         trim_reserved <= 64'h0;
         fuse_addr_o   <= 3'h0;
      end else if (clk_en) begin
         fuse_addr_o <= fuse_addr;
         if (loaded && fg_cal_en && pick != 3'h7) begin
            offset_corr  <= ofs_r[pick][`OGT_OFS_TRIM_MSB:0];
            offset_valid <= 1'b1;
         end else begin
            offset_corr  <= 12'h000;
            offset_valid <= 1'b0;
         end
         if (loaded) begin
            gain_trim_b0  <= gain_r[`OGT_GAIN_TRIM_MSB:0];
            // Offset nibbles sit in 47:28, gain reserved bits in 3:1
            trim_reserved <= {16'h0000, ofs_r[4][15:12], ofs_r[3][15:12],
                              ofs_r[2][15:12], ofs_r[1][15:12],
                              ofs_r[0][15:12], 24'h000000, gain_r[7:5],
                              1'b0};
         end
      end
   end
endmodule
`default_nettype wire

// ===== ogt_trim_regs_props.sv
`default_nettype none
module ogt_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        fg_cal_en,
   input wire logic        core_b_sel,
   input wire logic        input2_sel,
   input wire logic        phase90_sel,
   input wire logic [11:0] offset_corr,
   input wire logic        offset_valid,
   input wire logic [4:0]  gain_trim_b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // Helpers
   // ----------
   logic [3:0] up_r;
   wire        live = up_r == 4'hf;
   wire        take = hsel && hready && htrans[1] && clk_en;
   wire        sel  = clk_en && fg_cal_en && live;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Counts enabled cycles so checks start once fuse load is over
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         up_r <= 4'h0;
      else if (clk_en && !live)
         up_r <= up_r + 4'h1;
   end
   chk_zero_wait_ok: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait OKAY");
   chk_read_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   chk_idle_zero: assert property (
      clk_en && !fg_cal_en |=> !offset_valid && offset_corr == 12'h000)
      else $error("offset applied without calibration");
   chk_a_gap_none: assert property (
      sel && !core_b_sel && !input2_sel && !phase90_sel |=> !offset_valid)
      else $error("core a first input phase 0 applied");
   chk_b_ph90_none: assert property (
      sel && core_b_sel && phase90_sel |=> !offset_valid)
      else $error("core b phase 90 applied");
   chk_a_valid: assert property (
      sel && !core_b_sel && (input2_sel || phase90_sel) |=> offset_valid)
      else $error("core a offset not applied");
   chk_b_valid: assert property (
      sel && core_b_sel && !phase90_sel |=> offset_valid)
      else $error("core b offset not applied");
   // A write taken at one edge shows on the output two edges later
   chk_gain_steady: assert property (
      live && clk_en && !(take && hwrite) |-> ##3 $stable(gain_trim_b0))
      else $error("gain trim moved without a write");
endmodule
bind ogt_trim_regs ogt_props chk (.hclk, .hresetn, .clk_en, .hsel, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .fg_cal_en, .core_b_sel,
   .input2_sel, .phase90_sel, .offset_corr, .offset_valid, .gain_trim_b0);
`default_nettype wire

// ===== ogt_trim_regs_tb.sv
`default_nettype none
`include "ogt_map.vh"
module ogt_trim_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0;
   logic        fg_cal_en = 0, core_b_sel = 0, input2_sel = 0;
   logic        phase90_sel = 0, hreadyout, hresp, offset_valid;
   logic [1:0]  htrans = 0;
   logic [2:0]  fk = 0, fa;
   logic [4:0]  gain_trim_b0;
   logic [11:0] offset_corr;
   logic [15:0] fuse_rdata, fuse [8], mem [6];
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, w;
   logic [63:0] trim_reserved;
   int          errors = 0, checked = 0, n, j;
   always #5 hclk = ~hclk;
   // Hands out one fuse word per clock edge after release, whatever clk_en is
   always @(posedge hclk)
      if (hresetn && fk < 7) begin
         fk <= fk + 3'h1;
         fuse_rdata <= fuse[fk + 3'h1];
      end
   ogt_trim_regs dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .fuse_rdata, .fuse_addr_o(fa), .fg_cal_en,
      .core_b_sel, .input2_sel, .phase90_sel, .offset_corr, .offset_valid,
      .gain_trim_b0, .trim_reserved);
   // ----------
   // Tasks
   // ----------
   task automatic wrap_up;
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wt;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 99);
      if (n >= 99) begin
         errors++;
         wrap_up;
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, d);
      hsel <= 1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wt;
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      wt;
      rd = hrdata;
   endtask
   function automatic logic [31:0] ba(int i);
      return {18'h0, (i == 5 ? `OGT_IDX_BANK0_FINE_GAIN :
         `OGT_IDX_A_PH0_IN2 + 12'(2 * i)), 2'b00};
   endfunction
   // Register slot that should drive the applied offset, 7 for none
   function automatic int slot(logic f, b, s2, p);
      if (!f || (b && p) || (!b && !s2 && !p))
         return 7;
      return b ? 3 + s2 : (p ? 1 + s2 : 0);
   endfunction
   // ----------
   // Main sequence
   // ----------
   initial begin
      void'($urandom(32'he9a80e48));
      foreach (fuse[i]) fuse[i] = 16'($urandom);
      fuse_rdata = fuse[0];
      foreach (mem[i]) mem[i] = i == 5 ? {8'h0, fuse[5][7:0]} : fuse[i];
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      for (int k = 0; k < 20; k++) begin
         bus(0, {18'h0, `OGT_IDX_STATUS, 2'b00}, 0);
         if (rd[`OGT_ST_LOADED] === 1'b1)
            break;
      end
      cmp(rd[1:0], 2'b01);
      cmp(fa, `OGT_FUSE_WORDS - 1);
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 6; i++) begin
            bus(0, ba(i), 0);
            cmp(rd, {16'h0, mem[i]});
            w = $urandom;
            if (r == 1)
               w[15:12] = rd[15:12];
            mem[i] = i == 5 ? {8'h0, w[7:0]} : w[15:0];
            bus(1, ba(i), w);
         end
         bus(1, 32'hd1c, $urandom);
         bus(0, 32'hd1c, 0);
         cmp(rd, 0);
         for (int s = 0; s < 16; s++) begin
            @(posedge hclk);
            {fg_cal_en, core_b_sel, input2_sel, phase90_sel} <= 4'(s);
            @(posedge hclk);
            @(negedge hclk);
            j = slot(fg_cal_en, core_b_sel, input2_sel, phase90_sel);
            cmp({offset_valid, offset_corr},
               j == 7 ? 0 : {1'b1, mem[j][11:0]});
         end
         cmp(gain_trim_b0, mem[5][4:0]);
         cmp(trim_reserved[63:32], {16'h0, mem[4][15:12], mem[3][15:12],
            mem[2][15:12], mem[1][15:12]});
         cmp(trim_reserved[31:0], {mem[0][15:12], 24'h0, mem[5][7:5],
            1'b0});
         @(posedge hclk);
         // Clock enable low must freeze the applied offset
         w = {19'h0, offset_valid, offset_corr};
         clk_en <= 0;
         {fg_cal_en, core_b_sel, input2_sel, phase90_sel} <= 4'($urandom);
         repeat (3) @(posedge hclk);
         @(negedge hclk);
         cmp({offset_valid, offset_corr}, w);
         @(posedge hclk);
         clk_en <= 1;
      end
      wrap_up;
   end
endmodule
`default_nettype wire
